// ### aba_pkg.sv
// Constants for the address space and byte lane block.
// Assumes a single 10 MHz processor clock and an AXI4-Lite register bus.
package aba_pkg;
   localparam logic [31:0] ABA_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] ABA_STAT_OFS = 32'h0000_0004;
   localparam logic [31:0] ABA_CNT_OFS = 32'h0000_0008;
   // Control register bit positions
   localparam int ABA_WIDTH_EN_POS = 0;
   localparam int ABA_ORDER_POS = 1;
   localparam int ABA_TRAP_EN_POS = 2;
   localparam int ABA_ROM_EN_POS = 3;
   localparam int ABA_DXL_POS = 4;
   localparam int ABA_IXL_POS = 5;
   localparam logic [5:0] ABA_CTRL_RST = 6'h00;
   // Status register bit positions
   localparam int ABA_PTR_POS = 0;
   localparam int ABA_TRAP_POS = 4;
   localparam logic [1:0] ABA_PTR_RST = 2'h0;
   localparam logic [15:0] ABA_CNT_RST = 16'h0000;
   // Option field codes
   localparam logic [2:0] ABA_OPTION_WORD = 3'h0;
   localparam logic [2:0] ABA_OPTION_BYTE = 3'h1;
   localparam logic [2:0] ABA_OPTION_HALF = 3'h2;
   // Instruction space bits of an untranslated load or store
   localparam logic [1:0] ABA_SEL_MEM = 2'h0;
   localparam logic [1:0] ABA_SEL_IO = 2'h1;
   localparam logic [1:0] ABA_SEL_COP = 2'h2;
   localparam logic [1:0] ABA_RESP_OKAY = 2'h0;
   localparam logic [1:0] ABA_RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      ABA_SP_MEM = 2'b00,
      ABA_SP_IO = 2'b01,
      ABA_SP_COP = 2'b10,
      ABA_SP_ROM = 2'b11
   } aba_space_t;
endpackage

// ### aba_core.sv
// Address space selection, byte lane steering and alignment trap.
// Assumes the core offers one access per cycle on the req_ ports, same
// clock; registers are reached over AXI4-Lite.
`timescale 1ns/1ps

module aba_core
   import aba_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic req_valid,
   input wire logic req_fetch,
   input wire logic req_store,
   input wire logic [31:0] req_addr,
   input wire logic [2:0] req_option,
   input wire logic [1:0] req_space_bits,
   input wire logic req_supervisor,
   input wire logic req_real,
   input wire logic req_tlb_io,
   input wire logic req_sign_bit,
   output logic bus_valid,
   output logic [31:0] bus_addr,
   output logic [1:0] bus_space,
   output logic bus_instr,
   output logic bus_store,
   output logic bus_translated,
   output logic [2:0] bus_option,
   output logic [3:0] bus_lanes,
   output logic unaligned_trap,
   output logic [1:0] byte_pointer_field
);

   typedef struct packed {
      logic aw_held;
      logic [31:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [5:0] ctrl;
      logic [1:0] ptr;
      logic trap_seen;
      logic [15:0] trap_cnt;
      logic [29:0] pc;
      logic bus_valid;
      logic [31:0] bus_addr;
      logic [1:0] bus_space;
      logic bus_instr;
      logic bus_store;
      logic bus_translated;
      logic [2:0] bus_option;
      logic [3:0] bus_lanes;
      logic trap;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } aba_state_t;

   aba_state_t st;
   aba_state_t next_st;

   logic data_width_enable;
   logic byte_order_select;
   logic trap_unaligned_enable;
   logic rom_space_enable;
   logic dxl;
   logic ixl;
   assign data_width_enable = st.ctrl[ABA_WIDTH_EN_POS];
   assign byte_order_select = st.ctrl[ABA_ORDER_POS];
   assign trap_unaligned_enable = st.ctrl[ABA_TRAP_EN_POS];
   assign rom_space_enable = st.ctrl[ABA_ROM_EN_POS];
   assign dxl = st.ctrl[ABA_DXL_POS];
   assign ixl = st.ctrl[ABA_IXL_POS];

   // Access decode, all combinational on the request
   logic translated;
   aba_space_t space;
   logic is_word;
   logic is_half;
   logic is_byte;
   logic misaligned;
   logic trap_now;
   logic [1:0] byte_idx;
   logic hi_half;
   logic [3:0] lane_sel;

   always_comb begin
      if (req_fetch) begin
         translated = ixl;
         space = rom_space_enable ? ABA_SP_ROM : ABA_SP_MEM;
      end else begin
         translated = dxl & ~(req_supervisor & req_real);
         if (translated) begin
            space = req_tlb_io ? ABA_SP_IO : ABA_SP_MEM;
         end else if (req_space_bits == ABA_SEL_IO) begin
            space = ABA_SP_IO;
         end else if (req_space_bits == ABA_SEL_COP) begin
            space = ABA_SP_COP;
         end else begin
            space = ABA_SP_MEM;
         end
      end
   end

   assign is_word = req_option == ABA_OPTION_WORD;
   assign is_half = req_option == ABA_OPTION_HALF;
   assign is_byte = req_option == ABA_OPTION_BYTE;
   // Width judged from the option field alone, enable or not
   assign misaligned = (is_word && req_addr[1:0] != 2'h0) ||
      (is_half && req_addr[0]);
   // Store to ROM space is not checked or blocked
   assign trap_now = req_valid && !req_fetch && trap_unaligned_enable &&
      space == ABA_SP_MEM && misaligned;

   // Byte order flips the index; half select drops bit 0
   assign byte_idx = req_addr[1:0] ^ {2{~byte_order_select}};
   assign hi_half = req_addr[1] ^ ~byte_order_select;

   // Lane i holds bits 8*i+7 .. 8*i of the word
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         always_comb begin
            if (req_fetch || !data_width_enable || space == ABA_SP_COP) begin
               lane_sel[gi] = 1'b1;
            end else if (is_byte) begin
               lane_sel[gi] = byte_idx == 2'(gi);
            end else if (is_half) begin
               lane_sel[gi] = hi_half == (gi >= 2);
            end else begin
               lane_sel[gi] = 1'b1;
            end
         end
      end
   endgenerate

   // Register bus decode
   logic wr_go;
   logic rd_go;
   logic wr_ctrl;
   logic wr_stat;
   logic [31:0] rd_word;
   logic rd_hit;
   assign wr_go = st.aw_held && st.w_held && !st.bvalid;
   assign rd_go = s_axi_arvalid && !st.rvalid;
   assign wr_ctrl = wr_go && st.aw_addr[31:2] == ABA_CTRL_OFS[31:2];
   assign wr_stat = wr_go && st.aw_addr[31:2] == ABA_STAT_OFS[31:2];

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr[31:2])
         ABA_CTRL_OFS[31:2]: rd_word[5:0] = st.ctrl;
         ABA_STAT_OFS[31:2]: begin
            rd_word[ABA_PTR_POS +: 2] = st.ptr;
            rd_word[ABA_TRAP_POS] = st.trap_seen;
         end
         ABA_CNT_OFS[31:2]: rd_word[15:0] = st.trap_cnt;
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      next_st = st;
      // Write address and data are taken in either order
      if (s_axi_awvalid && !st.aw_held) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_held) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = (wr_ctrl || wr_stat ||
            st.aw_addr[31:2] == ABA_CNT_OFS[31:2]) ?
            ABA_RESP_OKAY : ABA_RESP_DECERR;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_ctrl && st.w_strb[0]) begin
         next_st.ctrl = st.w_data[5:0];
      end
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word;
         next_st.rresp = rd_hit ? ABA_RESP_OKAY : ABA_RESP_DECERR;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      // Trap flag: write one clears, a new trap wins
      if (wr_stat && st.w_strb[0] && st.w_data[ABA_TRAP_POS]) begin
         next_st.trap_seen = 1'b0;
      end
      if (trap_now) begin
         next_st.trap_seen = 1'b1;
         next_st.trap_cnt = st.trap_cnt + 16'h0001;
      end
      // Byte pointer loads on non-trapping data accesses with width off or sign bit set, never coprocessor ones
      if (req_valid && !req_fetch && !trap_now &&
         space != ABA_SP_COP) begin
         if (!data_width_enable) begin
            next_st.ptr = req_addr[1:0];
         end else if (req_sign_bit) begin
            next_st.ptr = {2{~byte_order_select}};
         end
      end
      // Outgoing access, one cycle after the request
      next_st.bus_valid = req_valid && !trap_now;
      next_st.trap = trap_now;
      if (req_valid) begin
         next_st.bus_space = space;
         next_st.bus_instr = req_fetch;
         next_st.bus_store = req_store && !req_fetch;
         next_st.bus_translated = translated;
         next_st.bus_option = req_option;
         next_st.bus_lanes = lane_sel;
         if (req_fetch) begin
            next_st.pc = req_addr[31:2];
            next_st.bus_addr = {req_addr[31:2], 2'h0};
         end else begin
            next_st.bus_addr = req_addr;
         end
      end
      next_st.aw_rdy = !next_st.aw_held;
      next_st.w_rdy = !next_st.w_held;
      next_st.ar_rdy = !next_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ctrl <= ABA_CTRL_RST;
         st.ptr <= ABA_PTR_RST;
         st.trap_cnt <= ABA_CNT_RST;
         st.aw_rdy <= 1'b1;
         st.w_rdy <= 1'b1;
         st.ar_rdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.aw_rdy;
   assign s_axi_wready = st.w_rdy;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.ar_rdy;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign bus_valid = st.bus_valid;
   assign bus_addr = st.bus_addr;
   assign bus_space = st.bus_space;
   assign bus_instr = st.bus_instr;
   assign bus_store = st.bus_store;
   assign bus_translated = st.bus_translated;
   assign bus_option = st.bus_option;
   assign bus_lanes = st.bus_lanes;
   assign unaligned_trap = st.trap;
   assign byte_pointer_field = st.ptr;

   // Checks on the driven access
   property p_fetch_low;
      @(posedge aclk) disable iff (!aresetn)
         bus_valid && bus_instr |-> bus_addr[1:0] == 2'h0;
   endproperty
   a_fetch_low: assert property (p_fetch_low)
      else $error("fetch address low bits not zero");

   property p_trap_blocks;
      @(posedge aclk) disable iff (!aresetn)
         unaligned_trap |-> !bus_valid;
   endproperty
   a_trap_blocks: assert property (p_trap_blocks)
      else $error("trapping access placed on bus");

   property p_trap_cause;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && !req_fetch && trap_unaligned_enable &&
         space == ABA_SP_MEM && req_option == ABA_OPTION_WORD &&
         req_addr[1:0] != 2'h0
         |=> unaligned_trap;
   endproperty
   a_trap_cause: assert property (p_trap_cause)
      else $error("unaligned word did not trap");

   property p_trap_gated;
      @(posedge aclk) disable iff (!aresetn)
         unaligned_trap |-> $past(trap_unaligned_enable) &&
         $past(space) == ABA_SP_MEM;
   endproperty
   a_trap_gated: assert property (p_trap_gated)
      else $error("trap without enable or outside memory");

   property p_cop_full;
      @(posedge aclk) disable iff (!aresetn)
         bus_valid && bus_space == ABA_SP_COP |-> bus_lanes == 4'hF;
   endproperty
   a_cop_full: assert property (p_cop_full)
      else $error("coprocessor transfer not full word");

   property p_width_off_full;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && !data_width_enable |=> bus_lanes == 4'hF;
   endproperty
   a_width_off_full: assert property (p_width_off_full)
      else $error("lanes narrowed with width disabled");

   property p_byte_order0;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && !req_fetch && data_width_enable && is_byte &&
         !byte_order_select && space != ABA_SP_COP && req_addr[1:0] == 2'h0
         |=> bus_lanes == 4'h8;
   endproperty
   a_byte_order0: assert property (p_byte_order0)
      else $error("order 0 byte 0 not high lane");

   property p_half_order1;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && !req_fetch && data_width_enable && byte_order_select &&
         is_half && space != ABA_SP_COP && !req_addr[1] |=> bus_lanes == 4'h3;
   endproperty
   a_half_order1: assert property (p_half_order1)
      else $error("order 1 half 0 not low half");

   property p_ptr_copy;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && !req_fetch && !data_width_enable && !trap_now &&
         space != ABA_SP_COP |=> byte_pointer_field == $past(req_addr[1:0]);
   endproperty
   a_ptr_copy: assert property (p_ptr_copy)
      else $error("byte pointer not loaded from address");

   property p_rom_fetch;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req_fetch && rom_space_enable |=> bus_space == ABA_SP_ROM;
   endproperty
   a_rom_fetch: assert property (p_rom_fetch)
      else $error("fetch not in ROM space");
endmodule

// ### aba_ext_side.sv
// Far-side model: memory, I/O and coprocessor behind the access bus.
// Assumes bus_* from aba_core, sampled at aclk rising edges.
`timescale 1ns/1ps
module aba_ext_side (
   input wire logic aclk,
   input wire logic bus_valid,
   input wire logic [31:0] bus_addr,
   input wire logic [1:0] bus_space,
   input wire logic bus_store,
   input wire logic [3:0] bus_lanes,
   output logic [29:0] last_word,
   output logic [3:0] lane_mask
);
   // One driver per output: state lives here, outputs only follow it
   logic [29:0] seen_word = '0;
   logic [3:0] seen_lanes = 4'h0;
   assign last_word = seen_word;
   assign lane_mask = seen_lanes;
   always @(posedge aclk) begin
      if (bus_valid) begin
         // Low bits dropped; fetches arrive word aligned, but data addresses may not
         seen_word <= bus_addr[31:2];
         // Space 3 is the ROM: stores there are absorbed, their lanes not recorded
         if (bus_store && bus_space != 2'h3) begin
            seen_lanes <= seen_lanes | bus_lanes;
         end
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for aba_core: AXI4-Lite control, access table.
// Assumes aba_pkg constants and the far-side model aba_ext_side.
`timescale 1ns/1ps
module testbench
   import aba_pkg::*;
;
   typedef struct packed {
      logic [5:0] ctrl;
      logic [1:0] fs;
      logic [1:0] a;
      logic [2:0] wid;
      logic [1:0] sp;
      logic [3:0] fl;
      logic v;
      logic [1:0] spc;
      logic [3:0] ln;
      logic tr;
      logic xl;
   } aba_row_t;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_valid = 1'b0;
   logic req_fetch = 1'b0, req_store = 1'b0, req_sign_bit = 1'b0;
   logic req_supervisor = 1'b0, req_real = 1'b0, req_tlb_io = 1'b0;
   logic [31:0] req_addr = '0;
   logic [2:0] req_option = 3'h0;
   logic [1:0] req_space_bits = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, bus_valid, bus_instr, bus_store, bus_translated;
   logic unaligned_trap;
   logic [1:0] s_axi_bresp, s_axi_rresp, bus_space, byte_pointer_field;
   logic [31:0] s_axi_rdata, bus_addr, rd;
   logic [2:0] bus_option;
   logic [3:0] bus_lanes, lane_mask, lm = 4'h0;
   logic [29:0] last_word;
   logic [5:0] cur;
   logic [1:0] ptr = 2'h0, rsp;
   int bad_count = 0, comparisons = 0, traps = 0;
   // ctrl, fetch/store, a, width, space bits, sv/real/tlb/sb -> expected
   aba_row_t rows [22] = '{
      '{6'h01,2'h0,2'h0,3'h1,2'h0,4'h0,1'b1,2'h0,4'h8,1'b0,1'b0},
      '{6'h01,2'h1,2'h3,3'h1,2'h0,4'h1,1'b1,2'h0,4'h1,1'b0,1'b0},
      '{6'h03,2'h0,2'h0,3'h1,2'h0,4'h0,1'b1,2'h0,4'h1,1'b0,1'b0},
      '{6'h01,2'h0,2'h3,3'h2,2'h0,4'h0,1'b1,2'h0,4'h3,1'b0,1'b0},
      '{6'h01,2'h0,2'h0,3'h2,2'h0,4'h0,1'b1,2'h0,4'hC,1'b0,1'b0},
      '{6'h03,2'h1,2'h1,3'h2,2'h0,4'h1,1'b1,2'h0,4'h3,1'b0,1'b0},
      '{6'h03,2'h0,2'h2,3'h2,2'h0,4'h0,1'b1,2'h0,4'hC,1'b0,1'b0},
      '{6'h04,2'h0,2'h2,3'h0,2'h0,4'h0,1'b0,2'h0,4'hF,1'b1,1'b0},
      '{6'h04,2'h0,2'h2,3'h2,2'h0,4'h0,1'b1,2'h0,4'hF,1'b0,1'b0},
      '{6'h04,2'h1,2'h3,3'h2,2'h0,4'h0,1'b0,2'h0,4'hF,1'b1,1'b0},
      '{6'h04,2'h0,2'h1,3'h0,2'h1,4'h0,1'b1,2'h1,4'hF,1'b0,1'b0},
      '{6'h05,2'h0,2'h3,3'h0,2'h2,4'h0,1'b1,2'h2,4'hF,1'b0,1'b0},
      '{6'h05,2'h0,2'h2,3'h1,2'h2,4'h1,1'b1,2'h2,4'hF,1'b0,1'b0},
      '{6'h00,2'h0,2'h1,3'h0,2'h0,4'h0,1'b1,2'h0,4'hF,1'b0,1'b0},
      '{6'h00,2'h0,2'h3,3'h1,2'h3,4'h0,1'b1,2'h0,4'hF,1'b0,1'b0},
      '{6'h10,2'h0,2'h0,3'h0,2'h0,4'h2,1'b1,2'h1,4'hF,1'b0,1'b1},
      '{6'h10,2'h0,2'h0,3'h0,2'h0,4'hE,1'b1,2'h0,4'hF,1'b0,1'b0},
      '{6'h10,2'h0,2'h0,3'h0,2'h0,4'h6,1'b1,2'h1,4'hF,1'b0,1'b1},
      '{6'h10,2'h0,2'h0,3'h0,2'h0,4'h0,1'b1,2'h0,4'hF,1'b0,1'b1},
      '{6'h08,2'h2,2'h3,3'h0,2'h0,4'h0,1'b1,2'h3,4'hF,1'b0,1'b0},
      '{6'h0C,2'h2,2'h2,3'h2,2'h0,4'h0,1'b1,2'h3,4'hF,1'b0,1'b0},
      '{6'h20,2'h2,2'h1,3'h0,2'h0,4'h0,1'b1,2'h0,4'hF,1'b0,1'b1}
   };
   aba_core i_aba_core (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .req_valid, .req_fetch, .req_store,
      .req_addr, .req_option, .req_space_bits, .req_supervisor, .req_real,
      .req_tlb_io, .req_sign_bit, .bus_valid, .bus_addr, .bus_space,
      .bus_instr, .bus_store, .bus_translated, .bus_option, .bus_lanes,
      .unaligned_trap, .byte_pointer_field);
   aba_ext_side i_aba_ext_side (.aclk, .bus_valid, .bus_addr, .bus_space,
      .bus_store, .bus_lanes, .last_word, .lane_mask);
   initial begin
      forever #50 aclk = ~aclk;
   end
   task automatic finish_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic drive(input aba_row_t r);
      req_valid <= 1'b1;
      {req_fetch, req_store} <= r.fs;
      req_addr <= {30'h48C, r.a};
      req_option <= r.wid;
      req_space_bits <= r.sp;
      {req_supervisor, req_real, req_tlb_io, req_sign_bit} <= r.fl;
   endtask
   task automatic look(input aba_row_t r);
      chk(32'({bus_valid,unaligned_trap}),32'({r.v,r.tr}));
      if (r.v) begin
         chk(32'(bus_space), 32'(r.spc));
         chk(32'(bus_lanes), 32'(r.ln));
         chk(32'(bus_translated), 32'(r.xl));
         chk(32'({bus_instr, bus_store}), 32'(r.fs));
         chk(32'(bus_option), 32'(r.wid));
         chk(bus_addr, {30'h48C, r.fs[1] ? 2'h0 : r.a});
         if (!r.fs[1] && r.spc != ABA_SP_COP) begin
            if (!r.ctrl[ABA_WIDTH_EN_POS]) ptr = r.a;
            else if (r.fl[0]) ptr = {2{~r.ctrl[ABA_ORDER_POS]}};
         end
         if (r.fs == 2'h1 && r.spc != ABA_SP_ROM) lm = lm | r.ln;
      end
      traps += int'(r.tr);
      chk(32'(byte_pointer_field), 32'(ptr));
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rdr(32'(4 * i));
         chk(rd, 32'h0);
      end
      // Unmapped place answers with an error and no data
      rdr(32'hC);
      chk(rd, 32'h0);
      chk(32'(rsp), 32'(ABA_RESP_DECERR));
      wr(32'hC, 32'h1);
      chk(32'(rsp), 32'(ABA_RESP_DECERR));
      wr(ABA_CTRL_OFS, 32'h3F);
      rdr(ABA_CTRL_OFS);
      chk(rd, 32'h3F);
      cur = 6'h3F;
      foreach (rows[i]) begin
         if (rows[i].ctrl != cur) begin
            wr(ABA_CTRL_OFS, 32'(rows[i].ctrl));
            cur = rows[i].ctrl;
         end
         @(posedge aclk);
         drive(rows[i]);
         @(posedge aclk);
         req_valid <= 1'b0;
         #1;
         look(rows[i]);
      end
      // Back to back: trapping word, then a clean half-word
      wr(ABA_CTRL_OFS, 32'h4);
      @(posedge aclk);
      drive(rows[7]);
      @(posedge aclk);
      drive(rows[8]);
      #1;
      look(rows[7]);
      @(posedge aclk);
      req_valid <= 1'b0;
      #1;
      look(rows[8]);
      rdr(ABA_STAT_OFS);
      chk(rd, {27'h0, 1'b1, 2'h0, ptr});
      wr(ABA_STAT_OFS, 32'h10);
      rdr(ABA_STAT_OFS);
      chk(rd, {30'h0, ptr});
      rdr(ABA_CNT_OFS);
      chk(rd, 32'(traps));
      chk(32'(lane_mask), 32'(lm));
      chk(32'(last_word), 32'h48C);
      // Second reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk(32'(byte_pointer_field), 32'h0);
      rdr(ABA_CTRL_OFS);
      chk(rd, 32'h0);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      finish_test();
   end
endmodule
